//--- rtl/fsr_defines.vh
// fsr_defines.vh: constants for the flash status reporting host controller
// assumes: included by bare name from fsr_host and fsr_flash_model
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH
// -----------------------------------------------------------------
// controller register offsets (word index on the software port)
// -----------------------------------------------------------------
`define FSR_REG_CTRL        4'h0
`define FSR_REG_ADDR        4'h1
`define FSR_REG_WDATA       4'h2
`define FSR_REG_STATUS      4'h3
`define FSR_REG_RDATA       4'h4
`define FSR_REG_FLASHSR     4'h5
// -----------------------------------------------------------------
// command codes written to ctrl[2:0]
// -----------------------------------------------------------------
`define FSR_CMD_WRITE       3'h1
`define FSR_CMD_READ        3'h2
`define FSR_CMD_SR_READ     3'h3
`define FSR_CMD_POLL        3'h4
// -----------------------------------------------------------------
// flash command bus values
// -----------------------------------------------------------------
`define FSR_SR_CMD_ADDR     24'h000555
`define FSR_SR_CMD_DATA     16'h0070
// -----------------------------------------------------------------
// status register and data-line polling bit positions on the flash
// -----------------------------------------------------------------
`define FSR_SR_READY        7
`define FSR_SR_ESUSP        6
`define FSR_SR_EFAIL        5
`define FSR_SR_PFAIL        4
`define FSR_SR_ABORT        3
`define FSR_SR_PSUSP        2
`define FSR_SR_LOCK         1
`define FSR_DL_TOGGLE       6
`define FSR_DL_TIMEOUT      5
// -----------------------------------------------------------------
// timing: strobe low and strobe high times in ns
// -----------------------------------------------------------------
`define FSR_T_STROBE_NS     50
`define FSR_T_HIGH_NS       30
`define FSR_CLK_NS          5
`define FSR_STROBE_CYC      ((`FSR_T_STROBE_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_HIGH_CYC        ((`FSR_T_HIGH_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_POLL_LIMIT      16'hffff
`endif

//--- rtl/fsr_sync.v
// fsr_sync.v: three-stage pin input synchroniser with agreement filter
// assumes: input is asynchronous to CLK
`timescale 1ns/1ps
module fsr_sync #(
    parameter W = 16                     // bus width
) (
    input  wire         clk,             // system clock
    input  wire         rst,             // sync reset
    input  wire [W-1:0] din,             // async input
    output reg  [W-1:0] dout             // filtered output
);
    // -----------------------------------------------------------------
    // sync chain
    // -----------------------------------------------------------------
    reg [W-1:0] s1_q;                    // first stage, read by s2 only
    reg [W-1:0] s2_q;                    // second stage
    reg [W-1:0] s3_q;                    // third stage

    // shift in, accept once stage two and three agree
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule // fsr_sync

//--- rtl/fsr_host.v
// fsr_host.v: host controller driving a parallel flash through its pins
// assumes: flash pins asynchronous; software port on CLK
//
// Notes on behaviour
// (R1) status read: command write, then read
// (R2) overlay ends; hold strobe high after read
// (R3) upper status byte ignored as don't-care
// (R4) bit7 ready; bits 6..1 valid when ready
// (R5) bit6 shows erase suspended
// (R6) bits 5,4 erase/program failure
// (R7) bit3 buffer abort, bit1 sector lock
// (R8) bit2 shows program suspended
// (R9) clear-status clears result bits only
// (R10) reset values: ready set, others clear
// (R11) program of suspended sector sets bit4
// (R12) after suspend, read until ready
// (R13) polling word on every read while busy
// (R14) line7 complement while programming
// (R15) line7 zero while erasing
// (R16) line7 valid only at target address
// (R17) protected program polls about 20 us
// (R18) protected erase polls about 100 us
// (R19) line6 inverts per read while busy
// (R20) line6 stops in suspend
// (R21) line3 set once erase begun
// (R22) line2 valid after final write strobe
// (R23) take data from read after line7 settles
// (R24) line2 toggles only in erase sector
// (R25) line5 set on pulse-count limit
// (R26) line1 set on buffer abort
// (R27) one toggle flip-flop per toggle bit
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_host #(
    parameter AW = 24,                   // flash address width
    parameter DW = 16                    // flash data width
) (
    input  wire          CLK,            // 200 MHz clock
    input  wire          RST,            // sync reset, high
    input  wire [3:0]    ADDR,           // register index
    input  wire [31:0]   WDATA,          // write data
    input  wire          WR,             // write strobe
    input  wire          RD,             // read strobe
    output reg  [31:0]   RDATA,          // read data, next cycle
    output reg  [AW-1:0] FL_A,           // flash address
    input  wire [DW-1:0] FL_DQ_I,        // flash data in
    output reg  [DW-1:0] FL_DQ_O,        // flash data out
    output reg           FL_DQ_OE,       // flash data drive enable
    output reg           FL_CE_N,        // chip select, low
    output reg           FL_OE_N,        // output enable, low
    output reg           FL_WE_N         // write strobe, low
);
    // -----------------------------------------------------------------
    // states
    // -----------------------------------------------------------------
    localparam S_IDLE  = 3'd0;           // waiting
    localparam S_WLOW  = 3'd1;           // write strobe low
    localparam S_RLOW  = 3'd2;           // read strobe low
    localparam S_HIGH  = 3'd3;           // strobes high gap
    localparam S_NEXT  = 3'd4;           // decide next step
    localparam [7:0] STROBE_C = `FSR_STROBE_CYC; // strobe low cycles
    localparam [7:0] HIGH_C   = `FSR_HIGH_CYC;   // strobe high cycles

    reg [2:0]    state_q;                // state
    reg [7:0]    cnt_q;                  // phase counter
    reg [2:0]    cmd_q;                  // running command
    reg          step_q;                 // second cycle flag
    reg          busy_q;                 // command active
    reg [AW-1:0] addr_q;                 // target address
    reg [DW-1:0] wdata_q;                // write data
    reg [DW-1:0] rdata_q;                // last array data
    reg [DW-1:0] fsr_q;                  // last status register
    reg [DW-1:0] prev_q;                 // previous poll word
    reg          havep_q;                // prev valid
    reg          done_ok_q;              // command finished; a status read also sets it when done_err_q is set
    reg          done_err_q;             // poll or status read finished failed
    reg [15:0]   polls_q;                // poll read count
    wire [DW-1:0] dq_s;                  // synced data

    // -----------------------------------------------------------------
    // pin input synchroniser
    // -----------------------------------------------------------------
    fsr_sync #(.W(DW)) u_sync (
        .clk  (CLK),
        .rst  (RST),
        .din  (FL_DQ_I),
        .dout (dq_s)
    );

    // toggle bit 6 compares between two successive reads
    function toggled;
        input [DW-1:0] a;
        input [DW-1:0] b;
        begin
            toggled = a[`FSR_DL_TOGGLE] ^ b[`FSR_DL_TOGGLE];
        end
    endfunction

    // -----------------------------------------------------------------
    // software register read port
    // -----------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            case (ADDR)
                `FSR_REG_ADDR:    RDATA <= {{(32-AW){1'b0}}, addr_q};
                `FSR_REG_WDATA:   RDATA <= {16'h0, wdata_q};
                `FSR_REG_STATUS:  RDATA <= {16'h0, polls_q[7:0], 5'h0,
                                            done_err_q, done_ok_q, busy_q};
                `FSR_REG_RDATA:   RDATA <= {16'h0, rdata_q};
                // (R3) upper byte masked as don't-care
                `FSR_REG_FLASHSR: RDATA <= {24'h0, fsr_q[7:0]};
                default:          RDATA <= 32'h0;
            endcase
        end else begin
            RDATA <= 32'h0;
        end
    end

    // -----------------------------------------------------------------
    // command sequencer and flash pin driver
    // -----------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            state_q    <= S_IDLE;
            cnt_q      <= 8'h0;
            cmd_q      <= 3'h0;
            step_q     <= 1'b0;
            busy_q     <= 1'b0;
            addr_q     <= {AW{1'b0}};
            wdata_q    <= {DW{1'b0}};
            rdata_q    <= {DW{1'b0}};
            // (R10) status copy starts at reset value
            fsr_q      <= 16'h0080;
            prev_q     <= {DW{1'b0}};
            havep_q    <= 1'b0;
            done_ok_q  <= 1'b0;
            done_err_q <= 1'b0;
            polls_q    <= 16'h0;
            FL_A       <= {AW{1'b0}};
            FL_DQ_O    <= {DW{1'b0}};
            FL_DQ_OE   <= 1'b0;
            FL_CE_N    <= 1'b1;
            FL_OE_N    <= 1'b1;
            FL_WE_N    <= 1'b1;
        end else begin
            // register writes while idle
            if (WR && !busy_q) begin
                case (ADDR)
                    `FSR_REG_ADDR:  addr_q  <= WDATA[AW-1:0];
                    `FSR_REG_WDATA: wdata_q <= WDATA[DW-1:0];
                    `FSR_REG_CTRL: begin
                        cmd_q      <= WDATA[2:0];
                        busy_q     <= 1'b1;
                        step_q     <= 1'b0;
                        havep_q    <= 1'b0;
                        done_ok_q  <= 1'b0;
                        done_err_q <= 1'b0;
                        polls_q    <= 16'h0;
                    end
                    default: ;
                endcase
            end
            case (state_q)
                S_IDLE: begin
                    if (busy_q) begin
                        cnt_q <= STROBE_C;
                        FL_CE_N <= 1'b0;
                        // (R1) first cycle writes overlay command
                        if (cmd_q == `FSR_CMD_WRITE ||
                            (cmd_q == `FSR_CMD_SR_READ && !step_q)) begin
                            FL_A     <= (cmd_q == `FSR_CMD_WRITE) ? addr_q :
                                        `FSR_SR_CMD_ADDR;
                            FL_DQ_O  <= (cmd_q == `FSR_CMD_WRITE) ? wdata_q :
                                        `FSR_SR_CMD_DATA;
                            FL_DQ_OE <= 1'b1;
                            FL_WE_N  <= 1'b0;
                            state_q  <= S_WLOW;
                        end else begin
                            // (R16) poll at the target address
                            FL_A    <= addr_q;
                            FL_OE_N <= 1'b0;
                            state_q <= S_RLOW;
                        end
                    end
                end
                S_WLOW: begin
                    if (cnt_q <= 8'h1) begin
                        FL_WE_N <= 1'b1;
                        state_q <= S_HIGH;
                        cnt_q   <= HIGH_C;
                    end else begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                S_RLOW: begin
                    if (cnt_q <= 8'h1) begin
                        // sample on the same edge that releases the strobe
                        FL_OE_N <= 1'b1;
                        if (cmd_q == `FSR_CMD_SR_READ) begin
                            fsr_q <= dq_s;
                        end else begin
                            rdata_q <= dq_s;
                        end
                        state_q <= S_HIGH;
                        cnt_q   <= HIGH_C;
                    end else begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                S_HIGH: begin
                    // (R2) strobes high for the minimum time
                    FL_DQ_OE <= 1'b0;
                    FL_CE_N  <= 1'b1;
                    if (cnt_q <= 8'h1) begin
                        state_q <= S_NEXT;
                    end else begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                S_NEXT: begin
                    state_q <= S_IDLE;
                    case (cmd_q)
                        `FSR_CMD_SR_READ: begin
                            if (!step_q) begin
                                step_q <= 1'b1;
                            // (R4) (R12) repeat until ready bit set
                            end else if (!fsr_q[`FSR_SR_READY]) begin
                                step_q <= 1'b0;
                            end else begin
                                busy_q    <= 1'b0;
                                done_ok_q <= 1'b1;
                                // (R6) (R7) failures flagged
                                done_err_q <= fsr_q[`FSR_SR_EFAIL] |
                                              fsr_q[`FSR_SR_PFAIL] |
                                              fsr_q[`FSR_SR_ABORT] |
                                              fsr_q[`FSR_SR_LOCK];
                            end
                        end
                        `FSR_CMD_POLL: begin
                            // (R19) poll word kept for the next toggle compare
                            prev_q  <= rdata_q;
                            havep_q <= 1'b1;
                            polls_q <= polls_q + 16'h1;
                            // (R19) (R20) toggle stopped means finished
                            if (havep_q && !toggled(prev_q, rdata_q)) begin
                                // (R23) one more read gives true data
                                cmd_q <= `FSR_CMD_READ;
                            // (R25) timeout: recheck once, then fail
                            end else if (havep_q && prev_q[`FSR_DL_TIMEOUT] &&
                                         rdata_q[`FSR_DL_TIMEOUT]) begin
                                busy_q     <= 1'b0;
                                done_err_q <= 1'b1;
                            // (R17) (R18) bounded poll
                            end else if (polls_q == `FSR_POLL_LIMIT) begin
                                busy_q     <= 1'b0;
                                done_err_q <= 1'b1;
                            end
                        end
                        default: begin
                            busy_q    <= 1'b0;
                            done_ok_q <= 1'b1;
                        end
                    endcase
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // fsr_host

//--- verif/fsr_host_monitor.sv
// fsr_host_monitor.sv: pin and port checks for the flash host
// assumes: bound to fsr_host from the testbench top
`timescale 1ns/1ps
module fsr_host_monitor (
    input wire logic        CLK,      // clock
    input wire logic        RST,      // sync reset
    input wire logic        RD,       // read strobe
    input wire logic [31:0] RDATA,    // read data
    input wire logic [23:0] FL_A,     // flash address
    input wire logic [15:0] FL_DQ_O,  // flash data out
    input wire logic        FL_DQ_OE, // data drive enable
    input wire logic        FL_CE_N,  // chip select
    input wire logic        FL_OE_N,  // output enable
    input wire logic        FL_WE_N   // write strobe
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read slot");
    strobe_excl_a: assert property (!(!FL_OE_N && !FL_WE_N))
        else $error("read and write strobes together");
    ce_strobe_a: assert property (!FL_OE_N || !FL_WE_N |-> !FL_CE_N)
        else $error("strobe without chip select");
    oe_drive_a: assert property (!FL_OE_N |-> !FL_DQ_OE)
        else $error("host drives data during read");
    we_drive_a: assert property (!FL_WE_N |-> FL_DQ_OE)
        else $error("write strobe without data");
    high_time_a: assert property ($rose(FL_OE_N) |-> FL_OE_N [*6])
        else $error("output enable high time short");
    we_pulse_a: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*8] ##[1:4] FL_WE_N)
        else $error("write strobe length wrong");
    read_hold_a: assert property (!FL_OE_N && $past(!FL_OE_N) |-> $stable(FL_A))
        else $error("address moved in read");
    sr_cmd_a: assert property ($fell(FL_WE_N) && FL_DQ_O == 16'h0070 |-> FL_A == 24'h000555)
        else $error("status command at wrong address");
    // main scenarios reached
    cover property ($fell(FL_WE_N));
    cover property ($rose(FL_OE_N));
    cover property (RD ##1 RDATA != 32'h0);
endmodule // fsr_host_monitor

//--- verif/fsr_flash_model.sv
// fsr_flash_model.sv: behavioural flash status side
// assumes: strobes from fsr_host, scenario loaded by the bench
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_flash_model #(
    parameter logic [15:0] ARR = 16'h5ac3  // array word at every address
) (
    input  wire logic [15:0] dq_i,   // data from host
    output wire logic [15:0] dq_o,   // data to host
    input  wire logic        ce_n,   // chip select
    input  wire logic        oe_n,   // output enable
    input  wire logic        we_n,   // write strobe
    input  wire logic        ld,     // load scenario
    input  wire logic [7:0]  nbusy,  // reads that stay busy
    input  wire logic [7:0]  sres,   // status bits when ready
    input  wire logic        f5      // timing limit flag
);
    logic [7:0]  cnt = 8'h00;  // busy reads left
    logic [6:0]  sr = 7'h00;   // status bits 6:0
    logic        ovl_req = 1'b0; // overlay entry toggle
    logic        ovl_ack = 1'b0; // overlay exit toggle
    logic        tog = 1'b0;   // toggle flip-flop
    logic [15:0] lst = 16'h0;  // last shown word
    logic [15:0] word;         // word now shown
    wire         ovl = ovl_req ^ ovl_ack; // overlay_mode
    // one program address: line7 inverted, line2 still
    always @* begin
        if (ovl)
            word = {~lst[15:8], cnt == 8'h00, (cnt == 8'h00) ? sr : ~sr};
        else if (cnt != 8'h00)
            word = {~lst[15:8], ~ARR[7], tog, f5, 5'h08};
        else
            word = ARR;
    end
    // released bus shows inverse of last word
    assign dq_o = (!ce_n && !oe_n) ? word : ~lst;
    always @(posedge we_n) begin
        if (!ce_n && dq_i == `FSR_SR_CMD_DATA)
            ovl_req <= ~ovl_req;
    end
    // read end: leave overlay, step toggle
    always @(posedge ld or posedge oe_n) begin
        if (ld) begin
            // busy read count bounds the polling time
            cnt <= nbusy;
            sr <= sres[6:0];
        end else begin
            lst <= word;
            ovl_ack <= ovl_req;
            // toggling stops once no longer busy
            if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                tog <= ~tog;
            end
        end
    end
endmodule // fsr_flash_model

//--- verif/tb.sv
// tb.sv: self-checking bench for fsr_host with flash model
// assumes: fsr_host, fsr_flash_model, fsr_host_monitor compiled
`timescale 1ns/1ps
module tb;
    logic        CLK = 0, RST = 1, WR = 0, RD = 0, ld = 0, f5 = 0;
    logic [3:0]  ADDR = 4'h0;     // register index
    logic [31:0] WDATA = 32'h0;   // write data
    logic [31:0] RDATA, e, m;     // read data, queued note
    logic [23:0] FL_A;            // flash address
    logic [15:0] FL_DQ_I, FL_DQ_O;// flash data
    logic        FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N;
    logic [7:0]  nbusy = 0, sres = 0; // model scenario
    logic [31:0] exp_q[$], msk_q[$]; // expected notes
    logic        pend = 0;        // read answer due
    logic [7:0]  codes [7];       // status bit scenarios
    int          n_errors = 0, checked = 0;
    fsr_host fsr_host_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .FL_A(FL_A), .FL_DQ_I(FL_DQ_I), .FL_DQ_O(FL_DQ_O),
        .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N));
    fsr_flash_model fsr_flash_model_i (.dq_i(FL_DQ_O), .dq_o(FL_DQ_I), .ce_n(FL_CE_N),
        .oe_n(FL_OE_N), .we_n(FL_WE_N), .ld(ld), .nbusy(nbusy), .sres(sres), .f5(f5));
    initial forever #2.5 CLK = ~CLK;
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // read, noting expected value under mask
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k,
                      output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back(x);
        msk_q.push_back(k);
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask
    // poll controller status until not busy
    task automatic wait_idle;
        logic [31:0] v;
        v = 32'h1;
        for (int i = 0; i < 600 && v[0] !== 1'b0; i++) rd(4'h3, 0, 0, v);
        if (v[0] !== 1'b0) begin
            n_errors++;
            $display("CHECK FAILED busy exp 0 got %b", v[0]);
        end
    endtask
    task automatic load(input logic [7:0] n, input logic [7:0] s, input logic f);
        @(posedge CLK);
        nbusy <= n;
        sres <= s;
        f5 <= f;
        ld <= 1'b1;
        @(posedge CLK);
        ld <= 1'b0;
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // compare oldest note with read data
    always @(posedge CLK) begin
        if (pend) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 0) begin
                checked++;
                if ((RDATA & m) !== e) begin
                    n_errors++;
                    $display("CHECK FAILED rdata exp %h got %h", e, RDATA & m);
                end
            end
        end
        pend <= RD;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v, a;
        v = $urandom(32'h0d8dc665);
        codes = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h00, 8'h40, 8'h04};
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        rd(4'h3, 32'h0, 32'h1, v);
        rd(4'h5, 32'h80, 32'hffffffff, v);
        rd(4'h9, 32'h0, 32'hffffffff, v);
        foreach (codes[k]) begin
            load(8'($urandom_range(3)), codes[k], 1'b0);
            a = {8'h0, 24'($urandom)};
            wr(4'h1, a);
            wr(4'h0, 32'h3);
            wr(4'h1, ~a);
            wait_idle();
            rd(4'h5, {24'h0, 8'h80 | codes[k]}, 32'hff, v);
            rd(4'h3, {29'h0, |(codes[k] & 8'h3a), 1'b1, 1'b0},
               32'h7, v);
            rd(4'h1, a, 32'hffffff, v);
        end
        // plain array write, data kept clear of the status command code
        a = {16'h0, 16'h8000 | 16'($urandom)};
        wr(4'h2, a);
        wr(4'h0, 32'h1);
        wait_idle();
        rd(4'h2, a, 32'hffff, v);
        rd(4'h3, 32'h2, 32'h7, v);
        // mid-run reset brings the status copy back to its reset value
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        rd(4'h5, 32'h80, 32'hff, v);
        rd(4'h3, 32'h0, 32'h7, v);
        load(8'h03, 8'h00, 1'b0);
        wr(4'h0, 32'h4);
        wait_idle();
        rd(4'h4, 32'h5ac3, 32'hffff, v);
        rd(4'h3, 32'h2, 32'h7, v);
        load(8'hc8, 8'h00, 1'b1);
        wr(4'h0, 32'h4);
        wait_idle();
        rd(4'h3, 32'h4, 32'h7, v);
        load(8'h00, 8'h00, 1'b0);
        wr(4'h0, 32'h2);
        wait_idle();
        rd(4'h4, 32'h5ac3, 32'hffff, v);
        complete_run();
    end
    // cut a hang short
    initial begin
        #150000;
        n_errors++;
        complete_run();
    end
endmodule // tb
bind fsr_host fsr_host_monitor fsr_host_monitor_i (.CLK(CLK), .RST(RST), .RD(RD),
    .RDATA(RDATA), .FL_A(FL_A), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
    .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N));
